// ==== hw/otw_top.sv ====
/*
  Overtemperature warning threshold and switching frequency select.
  Holds the warning limit and the switching frequency code, compares
  the limit against the temperature converter reading with a debounce,
  and presents the selected switching frequency.
  Assumes a simple synchronous register port decoded from PMBus by the
  caller, and a converter reading from logic on the same clock.
*/
// Functional notes
// RULE1: Host writes 8-bit warning limit; it is widened to a 9-bit threshold.
// RULE2: Threshold compared with top nine bits of converter reading, reading below.
// RULE3: Reading below threshold sets the overtemperature warning flag.
// RULE4: Flag rises only after the condition holds continuously for 100 ms.
// RULE5: Limit code is linear, 3.125 mV per step over 0 to 800 mV.
// RULE6: 6-bit frequency code in bits 5:0 picks a fixed switching frequency.
// RULE7: Threshold is limit with a zero LSB appended; bits 7:6 read zero.
`timescale 1ns/1ps
`include "otw_consts.svh"
module otw_top
  import otw_pkg::*;
#(
  parameter int unsigned TEMP_W = 12,
  parameter int unsigned DEBOUNCE_CYC = 32'(`OTW_DEBOUNCE_CYC),
  parameter int unsigned DEB_CNT_W = 25
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [TEMP_W-1:0] i_temp_sense_data,
  output logic o_ot_warn,
  output logic [5:0] o_fsw_code,
  output logic [15:0] o_fsw_freq
);
  // ==================================================
  // Frequency table, kHz times 100
  function automatic otw_fsw_freq_type fsw_freq(input otw_fsw_code_type code);
    case (code)
      6'h00: fsw_freq = 16'd3005;
      6'h01: fsw_freq = 16'd3255;
      6'h02: fsw_freq = 16'd3551;
      6'h03: fsw_freq = 16'd3906;
      6'h04: fsw_freq = 16'd4340;
      6'h05: fsw_freq = 16'd4883;
      6'h06: fsw_freq = 16'd5206;
      6'h07: fsw_freq = 16'd5580;
      6'h08: fsw_freq = 16'd6010;
      6'h09: fsw_freq = 16'd6510;
      6'h0A: fsw_freq = 16'd7102;
      6'h0B: fsw_freq = 16'd7813;
      6'h0C: fsw_freq = 16'd8681;
      6'h0D: fsw_freq = 16'd9766;
      6'h0E: fsw_freq = 16'd10081;
      6'h0F: fsw_freq = 16'd10417;
      6'h10: fsw_freq = 16'd10776;
      6'h11: fsw_freq = 16'd11161;
      6'h12: fsw_freq = 16'd11574;
      6'h13: fsw_freq = 16'd12019;
      6'h14: fsw_freq = 16'd12500;
      6'h15: fsw_freq = 16'd13021;
      6'h16: fsw_freq = 16'd13587;
      6'h17: fsw_freq = 16'd14205;
      6'h18: fsw_freq = 16'd14881;
      6'h19: fsw_freq = 16'd15625;
      6'h1A: fsw_freq = 16'd16447;
      6'h1B: fsw_freq = 16'd17361;
      6'h1C: fsw_freq = 16'd18382;
      6'h1D: fsw_freq = 16'd19531;
      6'h1E: fsw_freq = 16'd19841;
      6'h1F: fsw_freq = 16'd20161;
      6'h20: fsw_freq = 16'd20492;
      6'h21: fsw_freq = 16'd20833;
      6'h22: fsw_freq = 16'd21186;
      6'h23: fsw_freq = 16'd21552;
      6'h24: fsw_freq = 16'd21930;
      6'h25: fsw_freq = 16'd22321;
      6'h26: fsw_freq = 16'd22727;
      6'h27: fsw_freq = 16'd23148;
      6'h28: fsw_freq = 16'd23585;
      6'h29: fsw_freq = 16'd24038;
      6'h2A: fsw_freq = 16'd24510;
      6'h2B: fsw_freq = 16'd25000;
      6'h2C: fsw_freq = 16'd25510;
      6'h2D: fsw_freq = 16'd26042;
      6'h2E: fsw_freq = 16'd26596;
      6'h2F: fsw_freq = 16'd27174;
      6'h30: fsw_freq = 16'd27778;
      6'h31: fsw_freq = 16'd28409;
      6'h32: fsw_freq = 16'd29070;
      6'h33: fsw_freq = 16'd29762;
      6'h34: fsw_freq = 16'd30488;
      6'h35: fsw_freq = 16'd31250;
      6'h36: fsw_freq = 16'd32051;
      6'h37: fsw_freq = 16'd32895;
      6'h38: fsw_freq = 16'd33784;
      6'h39: fsw_freq = 16'd34722;
      6'h3A: fsw_freq = 16'd35714;
      6'h3B: fsw_freq = 16'd36765;
      6'h3C: fsw_freq = 16'd37879;
      6'h3D: fsw_freq = 16'd39063;
      6'h3E: fsw_freq = 16'd40323;
      6'h3F: fsw_freq = 16'd40323;
      default: fsw_freq = 16'd3005;
    endcase
  endfunction

  // ==================================================
  // Registers
  otw_byte_type overtemp_warning_limit_r;
  otw_fsw_code_type fsw_code_r;
  otw_thr_type thr;
  logic below_r;
  logic hit_lim;
  logic hit_fsw;

  assign hit_lim = (i_reg_addr == `OTW_LIMIT_ADDR);
  assign hit_fsw = (i_reg_addr == `OTW_FSW_ADDR);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      overtemp_warning_limit_r <= `OTW_LIMIT_RST;
    else if (i_reg_wr && hit_lim)
      overtemp_warning_limit_r <= i_reg_wdata; // RULE1 RULE5
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fsw_code_r <= `OTW_FSW_RST;
    else if (i_reg_wr && hit_fsw)
      fsw_code_r <= i_reg_wdata[`OTW_FSW_MSB:0]; // RULE6
  end

  // ==================================================
  // Read port
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd)
        o_reg_rdata <= 8'h00;
      else if (hit_lim)
        o_reg_rdata <= overtemp_warning_limit_r;
      else if (hit_fsw)
        o_reg_rdata <= {2'h0, fsw_code_r}; // RULE7
      else
        o_reg_rdata <= 8'h00;
    end
  end

  // ==================================================
  // Threshold compare
  assign thr = {overtemp_warning_limit_r, `OTW_THR_LSB}; // RULE7 RULE1

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      below_r <= 1'b0;
    else
      below_r <= (i_temp_sense_data[TEMP_W-1 -: 9] < thr); // RULE2
  end

  otw_debounce #(
    .CYC(DEBOUNCE_CYC),
    .CNT_W(DEB_CNT_W)
  ) u_deb (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_cond(below_r), // RULE3
    .o_flag(o_ot_warn)
  );

  // ==================================================
  // Frequency outputs
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_fsw_code <= `OTW_FSW_RST;
      o_fsw_freq <= `OTW_FSW_FREQ_RST;
    end
    else
    begin
      o_fsw_code <= fsw_code_r;
      o_fsw_freq <= fsw_freq(fsw_code_r); // RULE6
    end
  end

  // ==================================================
  // Checks
  logic [31:0] run_r;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      run_r <= 32'h0;
    else if (!below_r)
      run_r <= 32'h0;
    else if (run_r != 32'hFFFFFFFF)
      run_r <= run_r + 32'h1;
  end

  limit_to_thr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE1
    (i_reg_wr && hit_lim) |=> (thr == {$past(i_reg_wdata), 1'b0}))
    else $error("threshold not formed from written limit");

  compare_below_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE2
    ##1 (below_r == ($past(i_temp_sense_data[TEMP_W-1 -: 9]) < $past(thr))))
    else $error("compare result wrong");

  warn_needs_below_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE3
    o_ot_warn |-> $past(below_r))
    else $error("warning without below condition");

  warn_debounce_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE4
    $rose(o_ot_warn) |-> (run_r == DEBOUNCE_CYC))
    else $error("warning rose at wrong debounce count");

  limit_readback_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE5
    (i_reg_rd && hit_lim) |=> (o_reg_rvalid && o_reg_rdata == $past(overtemp_warning_limit_r)))
    else $error("limit readback wrong");

  fsw_table_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE6
    (i_reg_wr && hit_fsw && !i_reg_rd) |=> ##1 (o_fsw_freq == fsw_freq($past(i_reg_wdata[5:0], 2))))
    else $error("switching frequency output wrong");

  fsw_rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE7
    (i_reg_rd && hit_fsw) |=> (o_reg_rdata[7:6] == 2'h0))
    else $error("reserved frequency bits not zero");
endmodule

// ==== hw/otw_consts.svh ====
/*
  Offsets, field positions, reset values and timing counts for the
  overtemperature warning and switching frequency select block.
  Assumes a 200 MHz core clock.
*/
`ifndef OTW_CONSTS_SVH
`define OTW_CONSTS_SVH

// ==================================================
// Register offsets
`define OTW_LIMIT_ADDR 16'hFE1A
`define OTW_FSW_ADDR 16'hFE1B

// ==================================================
// Fields and reset values
`define OTW_FSW_MSB 5
`define OTW_LIMIT_RST 8'h00
`define OTW_FSW_RST 6'h00
`define OTW_FSW_FREQ_RST 16'h0BBD
`define OTW_THR_LSB 1'h0

// ==================================================
// Timing
`define OTW_CLK_HZ 64'd200000000
`define OTW_DEBOUNCE_MS 64'd100
`define OTW_DEBOUNCE_CYC (`OTW_DEBOUNCE_MS * `OTW_CLK_HZ / 64'd1000)

`endif

// ==== hw/otw_pkg.sv ====
/*
  Types shared by the overtemperature warning block.
  Assumes otw_consts.svh supplies the numeric constants.
*/
package otw_pkg;
  typedef logic [7:0] otw_byte_type;
  typedef logic [8:0] otw_thr_type;
  typedef logic [5:0] otw_fsw_code_type;
  typedef logic [15:0] otw_fsw_freq_type;
endpackage

// ==== hw/otw_debounce.sv ====
/*
  Debounce filter: output rises once the input has been high for
  CYC consecutive clocks, falls as soon as the input drops.
  Assumes the input is synchronous to i_clk.
*/
`timescale 1ns/1ps
module otw_debounce #(
  parameter int unsigned CYC = 20000000,
  parameter int unsigned CNT_W = 25
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cond,
  output logic o_flag
);
  // ==================================================
  // Hold counter
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_r <= '0;
    else if (!i_cond)
      cnt_r <= '0;
    else if (cnt_r != CNT_W'(CYC - 1))
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // ==================================================
  // Flag
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_flag <= 1'b0;
    else if (!i_cond)
      o_flag <= 1'b0;
    else if (cnt_r == CNT_W'(CYC - 1))
      o_flag <= 1'b1; // RULE4
  end
endmodule

// ==== tb/otw_host_model.sv ====
/*
  Behavioural host that issues register writes and reads on the
  strobe register port of the warning block.
  Assumes the port takes a strobe at the rising edge and answers a read one cycle later.
*/
`timescale 1ns/1ps
module otw_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [15:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  // ==================================================
  // Idle state
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 8'h00;
  end

  // ==================================================
  // Transfers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    #1;
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    for (i = 0; i < 4 && !ok; i++)
    begin
      if (i_reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = i_reg_rdata;
      end
      else
      begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
endmodule

// ==== tb/tb_overtemp_warning_and_fsw_select.sv ====
/*
  Self-checking bench for the warning limit and frequency select block.
  Assumes the host model drives the register port and the bench drives the reading.
*/
`timescale 1ns/1ps
module tb_overtemp_warning_and_fsw_select;
  import otw_pkg::*;
  localparam int unsigned DEB = 8;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, ot_warn, rd_ok;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic [11:0] temp = 12'h040;
  logic [5:0] fsw_code;
  logic [15:0] fsw_freq;
  int n_errors = 0;
  int samples_checked = 0;
  logic [5:0] row_code [6] = '{6'h00, 6'h01, 6'h16, 6'h20, 6'h2F, 6'h3F};
  logic [15:0] row_freq [6] = '{16'd3005, 16'd3255, 16'd13587, 16'd20492, 16'd27174, 16'd40323};

  always #2.5 i_clk = ~i_clk;

  otw_host_model i_host (.i_clk(i_clk), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  otw_top #(.TEMP_W(12), .DEBOUNCE_CYC(DEB), .DEB_CNT_W(4)) i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_temp_sense_data(temp),
    .o_ot_warn(ot_warn), .o_fsw_code(fsw_code), .o_fsw_freq(fsw_freq));

  // ==================================================
  // Helpers
  task automatic report_and_stop;
    $display("Errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    i_host.rd(a, rd_val, rd_ok);
    if (rd_ok !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: no read answer", $time);
      report_and_stop();
    end
    chk(16'(rd_val), 16'(exp));
  endtask

  // ==================================================
  // Sequence
  initial
  begin
    cyc(20);
    i_rst_b = 1'b1;
    chk(16'(ot_warn), 16'h0000);
    chk(16'(fsw_code), 16'h0000);
    chk(fsw_freq, 16'd3005);
    rd_chk(16'hFE1A, 8'h00);
    for (int r = 0; r < 6; r++)
    begin
      i_host.wr(16'hFE1B, {2'b11, row_code[r]});
      cyc(2);
      chk(16'(fsw_code), 16'(row_code[r]));
      chk(fsw_freq, row_freq[r]);
      rd_chk(16'hFE1B, {2'b00, row_code[r]});
    end
    i_host.wr(16'hFE1C, 8'h3F);
    rd_chk(16'hFE1C, 8'h00);
    rd_chk(16'hFE1B, 8'h3F);
    i_host.wr(16'hFE1A, 8'h04);
    rd_chk(16'hFE1A, 8'h04);
    cyc(DEB + 3);
    chk(16'(ot_warn), 16'h0000);
    temp = 12'h03F;
    cyc(DEB);
    chk(16'(ot_warn), 16'h0000);
    cyc(1);
    chk(16'(ot_warn), 16'h0001);
    temp = 12'h040;
    cyc(2);
    chk(16'(ot_warn), 16'h0000);
    temp = 12'h03F;
    cyc(5);
    temp = 12'h040;
    cyc(1);
    temp = 12'h03F;
    cyc(DEB);
    chk(16'(ot_warn), 16'h0000);
    cyc(1);
    chk(16'(ot_warn), 16'h0001);
    i_host.wr(16'hFE1A, 8'hFF);
    temp = 12'hFF0;
    cyc(DEB + 3);
    chk(16'(ot_warn), 16'h0000);
    temp = 12'hFEF;
    cyc(DEB + 1);
    chk(16'(ot_warn), 16'h0001);
    // Mid-run reset with the warning up and both registers written
    i_rst_b = 1'b0;
    cyc(2);
    chk(16'(ot_warn), 16'h0000);
    chk(16'(fsw_code), 16'h0000);
    chk(fsw_freq, 16'd3005);
    i_rst_b = 1'b1;
    rd_chk(16'hFE1A, 8'h00);
    // Read answer stands one cycle only
    cyc(1);
    chk(16'({reg_rvalid, reg_rdata}), 16'h0000);
    rd_chk(16'hFE1B, 8'h00);
    report_and_stop();
  end
endmodule
